/* common/fpc_defines.vh */
// constants for the flash program and erase controller
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
`define FPC_ARRAY_BYTES   1024
`define FPC_SECTOR_BYTES  256
`define FPC_PAGE_BYTES    16
`define FPC_ERASED        8'hFF
`define FPC_CLK_HZ        20000000
`define FPC_PROG_TIME_US  2000
`define FPC_PROG_CYCLES   ((`FPC_CLK_HZ / 1000000) * `FPC_PROG_TIME_US)
// command codes in control register bits 3:0
`define FPC_CMD_NONE      4'h0
`define FPC_CMD_LOAD      4'h1
`define FPC_CMD_PROG      4'h2
`define FPC_CMD_ERS_BYTE  4'h3
`define FPC_CMD_ERS_PAGE  4'h4
`define FPC_CMD_ERS_SECT  4'h5
`define FPC_CMD_ERS_CHIP  4'h6
`define FPC_CMD_CRC_SECT  4'h7
`define FPC_CMD_CRC_ALL   4'h8
`define FPC_CMD_WR_CFG    4'h9
`define FPC_CMD_WR_BOOT   4'hA
`define FPC_CMD_WR_VEC    4'hB
`define FPC_CMD_WR_SEC    4'hC
// register selects for the firmware port
`define FPC_SEL_CTRL      2'h0
`define FPC_SEL_DATA      2'h1
`define FPC_SEL_ADRL      2'h2
`define FPC_SEL_ADRH      2'h3
// status bits
`define FPC_ST_BUSY       7
`define FPC_ST_ERR        6
`define FPC_CRC_POLY      32'h04C1_1DB7
`define FPC_CRC_INIT      32'hFFFF_FFFF
`define FPC_SER_BITS      24
`endif

/* hw/fpc_flash_controller.v */
// flash program and erase controller with firmware and serial ports
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defines.vh"
module fpc_flash_controller #(
	parameter PROG_CYCLES = `FPC_PROG_CYCLES // erase/write time in clocks
) (
	input  wire        clk,          // 20 MHz clock
	input  wire        rst_n,        // synchronous reset, active low
	input  wire        fw_wr,        // firmware register write strobe
	input  wire [1:0]  fw_sel,       // firmware register select
	input  wire [7:0]  fw_wdata,     // firmware write data
	output reg  [7:0]  fw_rdata,     // firmware read data
	input  wire        isp_clk,      // programmer serial clock, sampled
	input  wire        isp_data_in,  // programmer serial data in
	output reg         isp_data_out, // serial data back to programmer
	output reg         isp_data_oe,  // high while this block drives data
	input  wire        isp_enable,   // in-circuit programming mode active
	input  wire        code_rd,      // code-space read instruction request
	input  wire [9:0]  code_addr,    // code-space read address
	output reg  [7:0]  code_rdata,   // code read data, zero when blocked
	output reg         code_blocked, // last read hit a secured sector
	output reg  [7:0]  user_config,  // active settings latched after each reset
	output reg         boot_status,  // boot status bit
	output reg  [7:0]  boot_vector,  // boot vector byte
	output reg  [31:0] crc_result,   // last crc result
	output wire        busy          // operation in progress
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	reg [7:0]  mem [0:`FPC_ARRAY_BYTES-1];  // code array
	reg [7:0]  pbuf [0:`FPC_PAGE_BYTES-1];  // page buffer
	reg [15:0] pvalid_reg;                  // buffered bytes per slot
	reg [7:0]  sec_reg [0:3];               // security bytes
	reg [7:0]  cfg_store_reg;               // stored config byte
	reg        cfg_loaded_reg;              // settings taken once
	reg [7:0]  data_reg;                    // data register
	reg [9:0]  addr_reg;                    // address registers
	reg [3:0]  cmd_reg;                     // running command
	reg        err_reg;                     // command refused
	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	localparam S_IDLE = 2'd0;
	localparam S_WORK = 2'd1;
	localparam S_WAIT = 2'd2;
	reg [1:0]  state_reg;
	reg [10:0] idx_reg;                     // walks the region
	reg [15:0] tmr_reg;                     // timing counter
	reg [31:0] crc_reg;
	reg [10:0] span;                        // region length
	reg [9:0]  base;                        // region start
	reg        is_erase;
	reg        is_crc;
	reg        start;
	reg [3:0]  start_cmd;
	reg        cmd_ok;
	reg [7:0]  mbyte;
	reg [31:0] crc_next;
	integer    k;
	reg [9:0]  cur_addr;                    // address of the request now
	reg [7:0]  cur_data;                    // data of the request now
	reg [10:0] span_reg;                    // latched region length
	reg [9:0]  base_reg;                    // latched region start
	// array address of the byte being worked on
	wire [9:0] waddr = base_reg + idx_reg[9:0];
	assign busy = (state_reg != S_IDLE);
	// ----------------------------------------------------------------
	// serial link: 24-bit frames {cmd4,pad2,addr10,data8}, msb first
	// ----------------------------------------------------------------
	reg        sclk_q_reg;                  // previous serial clock
	reg [23:0] sh_reg;
	reg [4:0]  bitcnt_reg;
	reg        ser_go_reg;                  // frame complete
	reg [7:0]  ser_out_reg;
	wire       s_rise = isp_clk & ~sclk_q_reg;
	wire       s_fall = ~isp_clk & sclk_q_reg;
	// programmer owns clock; device shifts on rise, answers on fall
	always @(posedge clk) begin
		if (!rst_n) begin
			sclk_q_reg   <= 1'b0;
			sh_reg       <= 24'h00_0000;
			bitcnt_reg   <= 5'd0;
			ser_go_reg   <= 1'b0;
			ser_out_reg  <= 8'h00;
			isp_data_out <= 1'b0;
			isp_data_oe  <= 1'b0;
		end else begin
			sclk_q_reg <= isp_clk;
			ser_go_reg <= 1'b0;
			if (!isp_enable) begin
				bitcnt_reg  <= 5'd0;
				isp_data_oe <= 1'b0;
			end else if (s_rise) begin
				sh_reg <= {sh_reg[22:0], isp_data_in};
				if (bitcnt_reg == `FPC_SER_BITS - 1) begin
					bitcnt_reg  <= 5'd0;
					ser_go_reg  <= 1'b1;
					ser_out_reg <= {busy, err_reg, 6'h00};
				end else begin
					bitcnt_reg <= bitcnt_reg + 5'd1;
				end
			end else if (s_fall) begin
				// status byte shifted back while the programmer clocks
				isp_data_oe  <= (bitcnt_reg < 5'd8);
				isp_data_out <= ser_out_reg[7];
				ser_out_reg  <= {ser_out_reg[6:0], 1'b0};
			end
		end
	end
	// ----------------------------------------------------------------
	// command decode from either party
	// ----------------------------------------------------------------
	always @* begin
		start     = 1'b0;
		start_cmd = `FPC_CMD_NONE;
		cur_addr  = addr_reg;
		cur_data  = data_reg;
		if (ser_go_reg) begin
			start     = 1'b1;
			start_cmd = sh_reg[23:20];
			// frame fields reach the registers only at this edge, so
			// the command must use them straight from the shifter
			cur_addr  = sh_reg[17:8];
			cur_data  = sh_reg[7:0];
		end else if (fw_wr && fw_sel == `FPC_SEL_CTRL && !isp_enable) begin
			start     = 1'b1;
			start_cmd = fw_wdata[3:0];
		end
		base = cur_addr;
		span = 11'd1;
		case (start_cmd)
			`FPC_CMD_ERS_PAGE: begin
				base = {cur_addr[9:4], 4'h0};
				span = 11'd`FPC_PAGE_BYTES;
			end
			`FPC_CMD_ERS_SECT, `FPC_CMD_CRC_SECT: begin
				base = {cur_addr[9:8], 8'h00};
				span = 11'd`FPC_SECTOR_BYTES;
			end
			`FPC_CMD_ERS_CHIP, `FPC_CMD_CRC_ALL: begin
				base = 10'd0;
				span = 11'd`FPC_ARRAY_BYTES;
			end
			`FPC_CMD_PROG: begin
				base = {cur_addr[9:4], 4'h0};
				span = 11'd`FPC_PAGE_BYTES;
			end
			default: begin
				base = cur_addr;
				span = 11'd1;
			end
		endcase
		cmd_ok = (start_cmd >= `FPC_CMD_PROG) && (start_cmd <= `FPC_CMD_WR_SEC);
	end
	// ----------------------------------------------------------------
	// crc step over one byte, msb first
	// ----------------------------------------------------------------
	always @* begin
		mbyte    = mem[waddr];                // latched region, not live decode
		crc_next = crc_reg;
		for (k = 7; k >= 0; k = k - 1) begin
			if (crc_next[31] ^ mbyte[k])
				crc_next = {crc_next[30:0], 1'b0} ^ `FPC_CRC_POLY;
			else
				crc_next = {crc_next[30:0], 1'b0};
		end
	end
	// ----------------------------------------------------------------
	// sequencer and register file
	// ----------------------------------------------------------------
	// commands arriving while busy are dropped, not queued
	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg      <= S_IDLE;
			cmd_reg        <= `FPC_CMD_NONE;
			err_reg        <= 1'b0;
			data_reg       <= 8'h00;
			addr_reg       <= 10'd0;
			pvalid_reg     <= 16'h0000;
			idx_reg        <= 11'd0;
			tmr_reg        <= 16'h0000;
			crc_reg        <= `FPC_CRC_INIT;
			crc_result     <= 32'h0000_0000;
			span_reg       <= 11'd0;
			base_reg       <= 10'd0;
			cfg_loaded_reg <= 1'b0;
			user_config    <= 8'h00;
		end else begin
			// settings fixed once after each reset
			if (!cfg_loaded_reg) begin
				user_config    <= cfg_store_reg;
				cfg_loaded_reg <= 1'b1;
			end
			if (ser_go_reg) begin
				addr_reg <= sh_reg[17:8];
				data_reg <= sh_reg[7:0];
			end else if (fw_wr && !isp_enable) begin
				case (fw_sel)
					`FPC_SEL_DATA: data_reg <= fw_wdata;
					`FPC_SEL_ADRL: addr_reg[7:0] <= fw_wdata;
					`FPC_SEL_ADRH: addr_reg[9:8] <= fw_wdata[1:0];
					default: ;
				endcase
			end
			case (state_reg)
				S_IDLE: begin
					if (start && start_cmd == `FPC_CMD_LOAD) begin
						// byte lands in its page slot
						pvalid_reg[cur_addr[3:0]] <= 1'b1;
					end else if (start && cmd_ok) begin
						err_reg   <= 1'b0;
						cmd_reg   <= start_cmd;
						base_reg  <= base;
						span_reg  <= span;
						idx_reg   <= 11'd0;
						tmr_reg   <= 16'h0000;
						crc_reg   <= `FPC_CRC_INIT;
						state_reg <= S_WORK;
					end else if (start && start_cmd != `FPC_CMD_NONE) begin
						err_reg <= 1'b1;
					end
				end
				S_WORK: begin
					// one byte per clock, then pad out the fixed time (crc commands skip the padding)
					tmr_reg <= tmr_reg + 16'd1;
					if (is_crc)
						crc_reg <= crc_next;
					if (idx_reg == span_reg - 11'd1)
						state_reg <= S_WAIT;
					else
						idx_reg <= idx_reg + 11'd1;
				end
				S_WAIT: begin
					tmr_reg <= tmr_reg + 16'd1;
					if (tmr_reg >= PROG_CYCLES[15:0] - 16'd1 || is_crc) begin
						if (is_crc)
							crc_result <= crc_reg;
						if (cmd_reg == `FPC_CMD_PROG)
							pvalid_reg <= 16'h0000;
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
	always @* begin
		is_crc   = (cmd_reg == `FPC_CMD_CRC_SECT) || (cmd_reg == `FPC_CMD_CRC_ALL);
		is_erase = (cmd_reg >= `FPC_CMD_ERS_BYTE) && (cmd_reg <= `FPC_CMD_ERS_CHIP);
	end
	// ----------------------------------------------------------------
	// array, page buffer and special bytes (no reset on flash cells)
	// ----------------------------------------------------------------
	// page buffer keeps its bytes; only the valid bits are cleared
	always @(posedge clk) begin
		if (state_reg == S_IDLE && start && start_cmd == `FPC_CMD_LOAD)
			pbuf[cur_addr[3:0]] <= cur_data;
		if (state_reg == S_WORK) begin
			if (is_erase)
				mem[waddr] <= `FPC_ERASED;
			else if (cmd_reg == `FPC_CMD_PROG && pvalid_reg[idx_reg[3:0]])
				mem[waddr] <= pbuf[idx_reg[3:0]];
		end
	end
	// special bytes take their data in the first work cycle
	// cells keep their value through reset, like the array
	always @(posedge clk) begin
		if (rst_n && state_reg == S_WORK && idx_reg == 11'd0) begin
			case (cmd_reg)
				`FPC_CMD_WR_CFG: cfg_store_reg <= data_reg;
				`FPC_CMD_WR_BOOT: boot_status <= data_reg[0];
				`FPC_CMD_WR_VEC: boot_vector <= data_reg;
				`FPC_CMD_WR_SEC: sec_reg[addr_reg[9:8]] <= data_reg;
				`FPC_CMD_ERS_CHIP: begin
					sec_reg[0] <= 8'h00;
					sec_reg[1] <= 8'h00;
					sec_reg[2] <= 8'h00;
					sec_reg[3] <= 8'h00;
				end
				default: ;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// code-space reads gated by sector security
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			code_rdata   <= 8'h00;
			code_blocked <= 1'b0;
		end else if (code_rd) begin
			code_blocked <= sec_reg[code_addr[9:8]][0];
			code_rdata   <= sec_reg[code_addr[9:8]][0] ? 8'h00 : mem[code_addr];
		end
	end
	// firmware read mux: status, data, address; no array readback
	always @* begin
		case (fw_sel)
			`FPC_SEL_CTRL: fw_rdata = {busy, err_reg, 2'b00, cmd_reg};
			`FPC_SEL_DATA: fw_rdata = data_reg;
			`FPC_SEL_ADRL: fw_rdata = addr_reg[7:0];
			`FPC_SEL_ADRH: fw_rdata = {6'h00, addr_reg[9:8]};
			default:       fw_rdata = 8'h00;
		endcase
	end
endmodule
`default_nettype wire

/* dv/fpc_props_properties.sv */
// port-level assertion checker for the flash controller
`timescale 1ns/100ps
`default_nettype none
module fpc_props #(
	parameter PROG_CYCLES = 50 // erase/write time in clocks
) (
	input wire logic        clk,          // system clock
	input wire logic        rst_n,        // sync reset, active low
	input wire logic        fw_wr,        // firmware write strobe
	input wire logic [1:0]  fw_sel,       // firmware register select
	input wire logic [7:0]  fw_wdata,     // firmware write data
	input wire logic        isp_enable,   // serial mode
	input wire logic        isp_data_oe,  // serial drive enable
	input wire logic [7:0]  code_rdata,   // code read data
	input wire logic        code_blocked, // read refused
	input wire logic [7:0]  user_config,  // active settings
	input wire logic [31:0] crc_result,   // crc value
	input wire logic        busy          // operation running
);
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic [15:0] bcnt_reg; // cycles spent busy
	logic [2:0]  up_reg;   // cycles since reset, saturating
	logic        crc_reg;  // last accepted command was a crc
	logic        acc;      // control write that should be taken
	logic        go;       // taken erase or crc command, which must raise busy
	assign acc = fw_wr && fw_sel == 2'h0 && !busy && !isp_enable;
	assign go  = acc && fw_wdata[3:0] >= 4'h3 && fw_wdata[3:0] <= 4'h8;
	// counters restart on reset so $past never sees stale spans
	always @(posedge clk) begin
		bcnt_reg <= (!rst_n || !busy) ? 16'h0000 : bcnt_reg + 16'h0001;
		up_reg   <= !rst_n ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
		crc_reg  <= !rst_n ? 1'b0 :
			(acc ? (fw_wdata[3:0] == 4'h7 || fw_wdata[3:0] == 4'h8) : crc_reg);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_busy_starts: assert property (go |=> busy)
		else $error("busy not raised by command");
	a_busy_holds: assert property ($rose(busy) |=> busy [*8])
		else $error("busy dropped too early");
	a_prog_span: assert property ($fell(busy) && !crc_reg |->
		$past(bcnt_reg) >= PROG_CYCLES - 2 && $past(bcnt_reg) <= PROG_CYCLES + 2)
		else $error("erase or write span wrong");
	a_done_in_time: assert property (bcnt_reg <= PROG_CYCLES + 1030)
		else $error("operation too long");
	a_isp_locks_fw: assert property (fw_wr && fw_sel == 2'h0 && isp_enable && !busy |=> !busy)
		else $error("firmware command taken in serial mode");
	a_blocked_zero: assert property (code_blocked |-> code_rdata == 8'h00)
		else $error("secured byte leaked");
	a_config_fixed: assert property (up_reg == 3'h7 |-> $stable(user_config))
		else $error("active settings changed");
	a_oe_idle: assert property (!isp_enable && !$past(isp_enable) |-> !isp_data_oe)
		else $error("serial data driven outside serial mode");
	a_crc_hold: assert property (!busy && !$past(busy) && !$past(busy, 2) |->
		$stable(crc_result))
		else $error("crc result changed while idle");
	c_chip_erase: cover property (go && fw_wdata[3:0] == 4'h6);
	c_blocked: cover property (code_blocked);
	c_done: cover property ($fell(busy));
endmodule
bind fpc_flash_controller fpc_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
	.clk(clk), .rst_n(rst_n), .fw_wr(fw_wr), .fw_sel(fw_sel), .fw_wdata(fw_wdata),
	.isp_enable(isp_enable), .isp_data_oe(isp_data_oe), .code_rdata(code_rdata),
	.code_blocked(code_blocked), .user_config(user_config), .crc_result(crc_result),
	.busy(busy));
`default_nettype wire

/* dv/fpc_isp_model.sv */
// external serial programmer model driving the clock, data and enable lines
`timescale 1ns/100ps
`default_nettype none
module fpc_isp_model (
	input  wire logic       clk,          // system clock for pacing
	input  wire logic       isp_data_out, // status bits back from the block
	output var  logic       isp_clk,      // serial clock, still between frames
	output var  logic       isp_data_in,  // serial data to the block
	output var  logic       isp_enable,   // serial mode level
	output var  logic [7:0] seen          // status read in a frame's first bits
);
	initial begin
		seen = 8'h00;
		isp_clk = 1'b0;
		isp_data_in = 1'b0;
		isp_enable = 1'b0;
	end
	// one frame msb first, data settled while the clock is low
	task automatic send(input logic [23:0] f);
		isp_enable = 1'b1;
		for (int i = 23; i >= 0; i--) begin
			repeat (3) @(posedge clk);
			#1 isp_data_in = f[i];
			repeat (3) @(posedge clk);
			// first eight clocks read back the previous frame's status
			#1 if (i >= 16) seen = {seen[6:0], isp_data_out};
			isp_clk = 1'b1;
			repeat (3) @(posedge clk);
			#1 isp_clk = 1'b0;
		end
		// released line shows the inverse, never the last bit
		isp_data_in = ~f[0];
	endtask
	// leave serial mode
	task automatic off;
		@(posedge clk);
		#1 isp_enable = 1'b0;
	endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the flash controller
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defines.vh"
module tb;
	localparam int PC = 1100; // shortened erase/write time, above the 1024-byte span
	logic        clk = 0, rst_n = 0, fw_wr = 0, code_rd = 0; // driven strobes
	logic [1:0]  fw_sel = 2'h0;                               // register select
	logic [7:0]  fw_wdata = 8'h00, fw_rdata, code_rdata;      // data paths
	logic [7:0]  user_config, boot_vector, d, img [0:15];     // outputs, images
	logic [9:0]  code_addr = 10'h000;                         // read address
	logic        isp_clk, isp_data_in, isp_enable, isp_data_out, isp_data_oe;
	logic        code_blocked, boot_status, busy;             // flags
	logic [31:0] crc_result;                                  // crc out
	logic [5:0]  p;                                           // page index
	logic [7:0]  st_seen;                                     // status read by model
	int          mismatches = 0, checks_done = 0, n;          // tallies
	always #25 clk = ~clk;
	fpc_flash_controller #(.PROG_CYCLES(PC)) dut (.clk(clk), .rst_n(rst_n), .fw_wr(fw_wr),
		.fw_sel(fw_sel), .fw_wdata(fw_wdata), .fw_rdata(fw_rdata), .isp_clk(isp_clk),
		.isp_data_in(isp_data_in), .isp_data_out(isp_data_out), .isp_data_oe(isp_data_oe),
		.isp_enable(isp_enable), .code_rd(code_rd), .code_addr(code_addr),
		.code_rdata(code_rdata), .code_blocked(code_blocked), .user_config(user_config),
		.boot_status(boot_status), .boot_vector(boot_vector), .crc_result(crc_result),
		.busy(busy));
	fpc_isp_model u_isp (.clk(clk), .isp_data_out(isp_data_out), .isp_clk(isp_clk),
		.isp_data_in(isp_data_in), .isp_enable(isp_enable), .seen(st_seen));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] s, input logic [7:0] v);
		@(posedge clk);
		#1 fw_wr = 1'b1;
		fw_sel = s;
		fw_wdata = v;
		@(posedge clk);
		#1 fw_wr = 1'b0;
	endtask
	// bounded wait for an operation to start and finish
	task automatic wt;
		for (int i = 0; i < 20 && busy !== 1'b1; i++) #50;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) #50;
		chk("busy_done", 0, {31'h0000_0000, busy});
	endtask
	task automatic op(input logic [3:0] c, input logic [9:0] a, input logic [7:0] v);
		wr(2'h2, a[7:0]);
		wr(2'h3, {6'h00, a[9:8]});
		wr(2'h1, v);
		wr(2'h0, {4'h0, c});
		wt();
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic b);
		@(posedge clk);
		#1 code_rd = 1'b1;
		code_addr = a;
		@(posedge clk);
		#1 code_rd = 1'b0;
		chk("code_rdata", {24'h00_0000, e}, {24'h00_0000, code_rdata});
		chk("code_blocked", {31'h0000_0000, b}, {31'h0000_0000, code_blocked});
	endtask
	// crc over n erased bytes, msb first, no final inversion
	function automatic logic [31:0] crc_ff(input int nb);
		logic [31:0] c;
		c = `FPC_CRC_INIT;
		for (int k = 0; k < nb * 8; k++)
			c = {c[30:0], 1'b0} ^ (!c[31] ? `FPC_CRC_POLY : 32'h0000_0000);
		return c;
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// watchdog: tests need about 21k cycles
	// ----------------------------------------
	initial begin
		#3000000;
		mismatches++;
		report_and_stop();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'ha70d));
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		chk("busy", 0, {31'h0000_0000, busy});
		op(4'h6, 10'h000, 8'h00);
		for (int i = 0; i < 6; i++) rd(10'($urandom), 8'hFF, 1'b0);
		$display("test array erase done");
		// full page first, then a partial one in another sector
		for (int t = 0; t < 2; t++) begin
			n = t ? 1 + $urandom % 15 : 16;
			p = 6'(t * 32 + 1 + $urandom % 15);
			for (int i = 0; i < n; i++) begin
				img[i] = 8'($urandom);
				op(4'h1, {p, 4'(i)}, img[i]);
			end
			op(4'h2, {p, 4'h0}, 8'h00);
			for (int i = 0; i < 16; i++) rd({p, 4'(i)}, i < n ? img[i] : 8'hFF, 1'b0);
		end
		$display("test page program done");
		op(4'h3, {p, 4'h0}, 8'h00);
		rd({p, 4'h0}, 8'hFF, 1'b0);
		op(4'h1, 10'h0F0, 8'h5A);
		op(4'h2, 10'h0F0, 8'h00);
		op(4'h1, 10'h100, 8'hA5);
		op(4'h2, 10'h100, 8'h00);
		op(4'h4, 10'h100, 8'h00);
		rd(10'h100, 8'hFF, 1'b0);
		rd(10'h0F0, 8'h5A, 1'b0);
		op(4'h5, 10'h000, 8'h00);
		rd(10'h0F0, 8'hFF, 1'b0);
		$display("test region erase done");
		op(4'hC, 10'h200, 8'h01);
		rd(10'h200, 8'h00, 1'b1);
		rd(10'h300, 8'hFF, 1'b0);
		op(4'h7, 10'h300, 8'h00);
		chk("crc_sector", crc_ff(256), crc_result);
		op(4'h6, 10'h000, 8'h00);
		rd(10'h200, 8'hFF, 1'b0);
		op(4'h8, 10'h000, 8'h00);
		chk("crc_all", crc_ff(1024), crc_result);
		$display("test security and crc done");
		d = 8'($urandom);
		op(4'hB, 10'h000, d);
		chk("boot_vector", {24'h00_0000, d}, {24'h00_0000, boot_vector});
		op(4'hA, 10'h000, 8'h01);
		chk("boot_status", 1, {31'h0000_0000, boot_status});
		// stored byte only becomes active at the next reset
		d = 8'($urandom);
		op(4'h9, 10'h000, d);
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		chk("busy", 0, {31'h0000_0000, busy});
		repeat (2) @(posedge clk);
		#1 chk("user_config", {24'h00_0000, d}, {24'h00_0000, user_config});
		op(4'h9, 10'h000, ~d);
		chk("user_config", {24'h00_0000, d}, {24'h00_0000, user_config});
		for (int c = 13; c < 16; c++) begin
			wr(2'h0, 8'(c));
			chk("err_bit", 1, {31'h0000_0000, fw_rdata[`FPC_ST_ERR]});
		end
		$display("test config and refusals done");
		// refused frame leaves the address register at 0x000 so a stale serial address shows
		op(4'h1, 10'h050, 8'h3C);
		op(4'h1, 10'h051, 8'hC3);
		op(4'h2, 10'h050, 8'h00);
		u_isp.send({4'hD, 2'h0, 10'h000, 8'h00});
		u_isp.send({4'h3, 2'h0, 10'h051, 8'h00});
		wt();
		u_isp.send(24'h00_0000);
		rd(10'h051, 8'hFF, 1'b0);
		rd(10'h050, 8'h3C, 1'b0);
		chk("isp_status", 32'h0000_0040, {24'h00_0000, st_seen});
		chk("isp_data_oe", 1, {31'h0000_0000, isp_data_oe});
		wr(2'h0, 8'h06);
		chk("busy", 0, {31'h0000_0000, busy});
		u_isp.off();
		@(posedge clk);
		#1 chk("isp_data_oe", 0, {31'h0000_0000, isp_data_oe});
		$display("test serial link done");
		report_and_stop();
	end
endmodule
`default_nettype wire
